//--- hdl/ssel_consts.svh
// Offsets, field positions, reset values and codes for the register set select block
`ifndef SSEL_CONSTS_SVH
`define SSEL_CONSTS_SVH
// Bus address (8-bit write form)
`define SMB_WR_ADDR 8'h30
// Shared register offsets
`define REG_STRAP 8'h00
`define REG_ID 8'h01
`define REG_SRST 8'h04
`define REG_INTF 8'h05
`define REG_DIAG 8'h06
`define REG_SEL 8'hff
// Channel register offsets
`define CH_REG_RST 8'h00
`define CH_REG_CDR 8'h0a
`define CH_REG_ADAPT 8'h31
// Field positions
`define SRST_BIT 6
`define INT_A_BIT 3
`define INT_B_BIT 2
`define SEL_BCAST 3
`define SEL_CHEN 2
`define CH_RST_BIT 2
`define CDR_OVR_BIT 3
`define CDR_HOLD_BIT 2
`define ADAPT_HI 6
`define ADAPT_LO 5
// Values
`define DIAG_KEY 4'ha
`define SHARED_RST 8'h00
`define CH_R00_RST 8'h00
`define CH_R0A_RST 8'h00
`define CH_R31_RST 8'h00
`endif

//--- hdl/ssel_pkg.sv
// Types for the register set select block
package ssel_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_CMD = 3'b010,
		S_WDAT = 3'b011,
		S_ACK = 3'b100,
		S_RDAT = 3'b101,
		S_MACK = 3'b110,
		S_IGN = 3'b111
	} state_t;
endpackage : ssel_pkg

//--- hdl/chan_regs.sv
// One channel register set with soft reset and CDR hold override
`timescale 1ns/100ps
`include "ssel_consts.svh"
module chan_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Access
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_q,
	// CDR side
	input wire logic sig_det,
	output logic cdr_hold_q,
	output logic lock_start_q,
	output logic [1:0] adapt_mode
);
	logic [7:0] r00_q;
	logic [7:0] r0a_q;
	logic [7:0] r31_q;
	logic ch_clr;
	logic hold_d;

	// Soft reset of the whole set, bit itself never stored
	assign ch_clr = wr_en && addr == `CH_REG_RST && wdata[`CH_RST_BIT];
	assign hold_d = r0a_q[`CDR_OVR_BIT] & r0a_q[`CDR_HOLD_BIT];
	assign adapt_mode = r31_q[`ADAPT_HI:`ADAPT_LO];

	////////////////////////////////////////////////////////////////
	// Register storage
	always_ff @(posedge clk) begin
		if (reset || ch_clr) begin
			r00_q <= `CH_R00_RST;
			r0a_q <= `CH_R0A_RST;
			r31_q <= `CH_R31_RST;
		end else if (wr_en) begin
			if (addr == `CH_REG_RST) begin
				r00_q <= wdata & ~(8'h01 << `CH_RST_BIT);
			end else if (addr == `CH_REG_CDR) begin
				r0a_q <= wdata;
			end else if (addr == `CH_REG_ADAPT) begin
				r31_q <= wdata;
			end
		end
	end

	// Hold only restarts the sequence; configuration is untouched
	always_ff @(posedge clk) begin
		if (reset) begin
			cdr_hold_q <= 1'b0;
			lock_start_q <= 1'b0;
		end else begin
			cdr_hold_q <= hold_d;
			lock_start_q <= cdr_hold_q & ~hold_d & sig_det;
		end
	end

	// Read data from a register, unmapped reads as zero
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (addr == `CH_REG_RST) begin
			rdata_q <= r00_q;
		end else if (addr == `CH_REG_CDR) begin
			rdata_q <= r0a_q;
		end else if (addr == `CH_REG_ADAPT) begin
			rdata_q <= r31_q;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	a_chan_selfclr: assert property (@(posedge clk) disable iff (reset)
		ch_clr |=> r00_q == `CH_R00_RST && r0a_q == `CH_R0A_RST && r31_q == `CH_R31_RST)
		else $error("channel soft reset did not restore defaults");
	a_cdr_hold: assert property (@(posedge clk) disable iff (reset)
		(wr_en && addr == `CH_REG_CDR && wdata[3:2] == 2'b11) |=> ##1 cdr_hold_q)
		else $error("CDR hold not applied");
	a_config_kept: assert property (@(posedge clk) disable iff (reset)
		(cdr_hold_q && !wr_en) |=> $stable(r31_q) && $stable(r00_q))
		else $error("config changed during CDR hold");
	a_lock_start: assert property (@(posedge clk) disable iff (reset)
		($fell(cdr_hold_q) && $past(sig_det)) |-> lock_start_q)
		else $error("no lock start after CDR release");
endmodule : chan_regs

//--- hdl/smbus_register_set_select.sv
// Bus slave, shared registers and channel set routing for a two-channel retimer
// Operation
// - Key 0xa in diag bits 3:0 enables observation
// - Observed strap is power-up capture, not pin
// - Slave answers at write address 0x30
// - Shared reset bit restores defaults, self-clears
// - Flags bits 3 and 2 show channel interrupts
// - Register revision_and_id returns revision and ID
// - Broadcast bit writes all channel sets
// - Reads come from target channel only
// - Enable bit routes accesses to channel sets
// - Address register_set_select writes always hit select
// - Select register is write-only
// - Select values decode shared, A, B, broadcast
// - Channel reset bit restores channel defaults
// - Override plus hold bit holds CDR reset
// - CDR hold leaves configuration unchanged
// - Release with signal detected restarts lock with set adapt mode
`timescale 1ns/100ps
`include "ssel_consts.svh"
module smbus_register_set_select #(
	parameter logic [2:0] DEV_REV = 3'h1, // Arbitrary value
	parameter logic [4:0] DEV_ID = 5'h05 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial bus, open drain data
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Address strap
	input wire logic [3:0] addr_strap,
	// Channel events
	input wire logic int_a,
	input wire logic int_b,
	input wire logic sig_det_a,
	input wire logic sig_det_b,
	// CDR control per channel
	output logic cdr_hold_a,
	output logic cdr_hold_b,
	output logic lock_start_a,
	output logic lock_start_b,
	output logic [1:0] adapt_mode_a,
	output logic [1:0] adapt_mode_b
);
	////////////////////////////////////////////////////////////////
	// Bus line sampling
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// Previous levels for edge and condition detection
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	// Data moving while clock high marks start or stop
	assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
	assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;

	////////////////////////////////////////////////////////////////
	// Byte-level protocol engine
	ssel_pkg::state_t st_q;
	ssel_pkg::state_t nxt_q;
	logic [3:0] cnt_q;
	logic [7:0] shreg_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic [7:0] rd_q;
	logic sda_oe_q;
	logic wr_stb_q;
	logic addr_hit;

	// Seven address bits compared, direction bit masked
	assign addr_hit = {shreg_q[7:1], 1'b0} == `SMB_WR_ADDR;

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_q;

	// Start and stop win over any byte in progress
	always_ff @(posedge clk) begin
		wr_stb_q <= 1'b0;
		if (reset) begin
			st_q <= ssel_pkg::S_IDLE;
			nxt_q <= ssel_pkg::S_IDLE;
			cnt_q <= 4'h0;
			shreg_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			sda_oe_q <= 1'b0;
		end else if (bus_start) begin
			st_q <= ssel_pkg::S_ADDR;
			cnt_q <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (bus_stop) begin
			st_q <= ssel_pkg::S_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			case (st_q)
				ssel_pkg::S_ADDR, ssel_pkg::S_CMD, ssel_pkg::S_WDAT: begin
					if (scl_rise) begin
						shreg_q <= {shreg_q[6:0], sda_in};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						cnt_q <= 4'h0;
						if (st_q == ssel_pkg::S_ADDR) begin
							if (addr_hit) begin
								sda_oe_q <= 1'b1;
								st_q <= ssel_pkg::S_ACK;
								nxt_q <= shreg_q[0] ? ssel_pkg::S_RDAT : ssel_pkg::S_CMD;
							end else begin
								st_q <= ssel_pkg::S_IGN;
							end
						end else begin
							sda_oe_q <= 1'b1;
							st_q <= ssel_pkg::S_ACK;
							nxt_q <= ssel_pkg::S_WDAT;
							if (st_q == ssel_pkg::S_CMD) begin
								ptr_q <= shreg_q;
							end else begin
								wr_stb_q <= 1'b1;
							end
						end
					end
				end
				ssel_pkg::S_ACK: begin
					// End of ninth clock: release or drive first data bit
					if (scl_fall) begin
						st_q <= nxt_q;
						cnt_q <= 4'h0;
						if (nxt_q == ssel_pkg::S_RDAT) begin
							tx_q <= {rd_q[6:0], 1'b0};
							sda_oe_q <= ~rd_q[7];
						end else begin
							sda_oe_q <= 1'b0;
						end
					end
				end
				ssel_pkg::S_RDAT: begin
					if (scl_rise) begin
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							sda_oe_q <= 1'b0;
							st_q <= ssel_pkg::S_MACK;
						end else begin
							sda_oe_q <= ~tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
				end
				ssel_pkg::S_MACK: begin
					// Controller ack repeats the same register, nack ends
					if (scl_rise) begin
						nxt_q <= ssel_pkg::S_RDAT;
						st_q <= sda_in ? ssel_pkg::S_IGN : ssel_pkg::S_ACK;
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Routing of accesses between shared and channel sets
	logic [7:0] sel_q;
	logic ptr_sel;
	logic chan_en;
	logic bcast;
	logic wr_sh;
	logic wr_a;
	logic wr_b;

	assign ptr_sel = ptr_q == `REG_SEL;
	assign chan_en = sel_q[`SEL_CHEN];
	assign bcast = sel_q[`SEL_BCAST];
	// Select address is never a channel register
	assign wr_sh = wr_stb_q & (ptr_sel | ~chan_en);
	// Target A is select 0x04/0x0c, B is 0x05/0x0d; broadcast hits both
	assign wr_a = wr_stb_q & ~ptr_sel & chan_en & (bcast | ~sel_q[0]);
	assign wr_b = wr_stb_q & ~ptr_sel & chan_en & (bcast | sel_q[0]);

	////////////////////////////////////////////////////////////////
	// Shared registers
	logic [7:0] srst_q;
	logic [7:0] diag_q;
	logic shared_clr;
	logic obs_en;

	// Shared reset clears everything shared, select included
	assign shared_clr = wr_sh && ptr_q == `REG_SRST && shreg_q[`SRST_BIT];
	assign obs_en = diag_q[3:0] == `DIAG_KEY;

	// Upper select nibble stored as written; controller keeps it zero
	always_ff @(posedge clk) begin
		if (reset || shared_clr) begin
			srst_q <= `SHARED_RST;
			diag_q <= `SHARED_RST;
			sel_q <= `SHARED_RST;
		end else if (wr_sh) begin
			if (ptr_q == `REG_SEL) begin
				sel_q <= shreg_q;
			end else if (ptr_q == `REG_SRST) begin
				srst_q <= shreg_q & ~(8'h01 << `SRST_BIT);
			end else if (ptr_q == `REG_DIAG) begin
				diag_q <= shreg_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Strap capture once after reset release
	logic [3:0] strap_q;
	logic strap_cap_q;

	// Later pin changes are ignored so the read stays the power-up level
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_q <= 4'h0;
			strap_cap_q <= 1'b0;
		end else if (!strap_cap_q) begin
			strap_q <= addr_strap;
			strap_cap_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data path
	logic [7:0] sh_rd;
	logic [7:0] rdat_a;
	logic [7:0] rdat_b;

	// Shared read multiplexer
	always_comb begin
		if (ptr_q == `REG_STRAP) begin
			sh_rd = {obs_en ? strap_q : 4'h0, 4'h0};
		end else if (ptr_q == `REG_ID) begin
			sh_rd = {DEV_REV, DEV_ID};
		end else if (ptr_q == `REG_SRST) begin
			sh_rd = srst_q;
		end else if (ptr_q == `REG_INTF) begin
			sh_rd = 8'h00;
			sh_rd[`INT_A_BIT] = int_a;
			sh_rd[`INT_B_BIT] = int_b;
		end else if (ptr_q == `REG_DIAG) begin
			sh_rd = diag_q;
		end else begin
			sh_rd = 8'h00;
		end
	end

	// Ready long before the ack ends, so no read strobe is needed
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_q <= 8'h00;
		end else if (ptr_sel) begin
			rd_q <= 8'h00;
		end else if (chan_en) begin
			rd_q <= sel_q[0] ? rdat_b : rdat_a;
		end else begin
			rd_q <= sh_rd;
		end
	end

	////////////////////////////////////////////////////////////////
	// Channel register sets
	chan_regs u_chan_a (
		.clk(clk),
		.reset(reset),
		.wr_en(wr_a),
		.addr(ptr_q),
		.wdata(shreg_q),
		.rdata_q(rdat_a),
		.sig_det(sig_det_a),
		.cdr_hold_q(cdr_hold_a),
		.lock_start_q(lock_start_a),
		.adapt_mode(adapt_mode_a)
	);

	chan_regs u_chan_b (
		.clk(clk),
		.reset(reset),
		.wr_en(wr_b),
		.addr(ptr_q),
		.wdata(shreg_q),
		.rdata_q(rdat_b),
		.sig_det(sig_det_b),
		.cdr_hold_q(cdr_hold_b),
		.lock_start_q(lock_start_b),
		.adapt_mode(adapt_mode_b)
	);

	////////////////////////////////////////////////////////////////
	// Checks
	a_strap_observe: assert property (@(posedge clk) disable iff (reset)
		(ptr_q == `REG_STRAP && !chan_en && $stable(ptr_q) && $stable(sel_q))
		|=> rd_q[7:4] == ($past(obs_en) ? $past(strap_q) : 4'h0))
		else $error("strap field wrong for key state");
	a_strap_frozen: assert property (@(posedge clk) disable iff (reset)
		$past(strap_cap_q) |-> $stable(strap_q))
		else $error("strap value changed after capture");
	a_addr_match: assert property (@(posedge clk) disable iff (reset)
		($past(st_q) == ssel_pkg::S_ADDR && st_q == ssel_pkg::S_ACK)
		|-> $past(shreg_q[7:1]) == 7'h18 && sda_oe_q)
		else $error("acked a foreign address");
	a_shared_clear: assert property (@(posedge clk) disable iff (reset)
		shared_clr |=> srst_q == 8'h00 && diag_q == 8'h00 && sel_q == 8'h00)
		else $error("shared reset incomplete");
	a_int_flags: assert property (@(posedge clk) disable iff (reset)
		(ptr_q == `REG_INTF && !chan_en && !ptr_sel)
		|=> rd_q[3:2] == {$past(int_a), $past(int_b)})
		else $error("interrupt flags misreported");
	a_id_read: assert property (@(posedge clk) disable iff (reset)
		(ptr_q == `REG_ID && !chan_en) |=> rd_q == {DEV_REV, DEV_ID})
		else $error("revision and id wrong");
	a_bcast_write: assert property (@(posedge clk) disable iff (reset)
		(wr_stb_q && chan_en && bcast && !ptr_sel) |-> wr_a && wr_b && !wr_sh)
		else $error("broadcast write missed a channel");
	a_read_target: assert property (@(posedge clk) disable iff (reset)
		(chan_en && !ptr_sel) |=> rd_q == ($past(sel_q[0]) ? $past(rdat_b) : $past(rdat_a)))
		else $error("read from wrong channel");
	a_shared_route: assert property (@(posedge clk) disable iff (reset)
		(wr_stb_q && !chan_en) |-> !wr_a && !wr_b && wr_sh)
		else $error("shared write leaked to channel");
	a_sel_write: assert property (@(posedge clk) disable iff (reset)
		(wr_stb_q && ptr_sel) |-> !wr_a && !wr_b ##1 sel_q == $past(shreg_q))
		else $error("select write misrouted");
	a_sel_readzero: assert property (@(posedge clk) disable iff (reset)
		ptr_sel |=> rd_q == 8'h00)
		else $error("select register read not zero");
endmodule : smbus_register_set_select

//--- tb/smbus_ctrl_model.sv
// Bus controller model: drives the bus clock and data pull-down, samples the wire
`timescale 1ns/100ps
module smbus_ctrl_model (
	// Clock
	input wire logic clk,
	// Bus wires
	input wire logic sda,
	output logic scl,
	output logic m_oe
);
	// Bus idles released with clock high
	initial begin
		scl = 1'b1;
		m_oe = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Six clocks a phase, above the slave's minimum of one
	task automatic ph;
		repeat (6) @(posedge clk);
	endtask : ph
	// Start or repeated start: data falls while the clock is high
	task automatic st;
		@(posedge clk);
		m_oe <= 1'b0;
		ph();
		scl <= 1'b1;
		ph();
		m_oe <= 1'b1;
		ph();
		scl <= 1'b0;
	endtask : st
	// Stop: data rises while the clock is high
	task automatic sp;
		@(posedge clk);
		m_oe <= 1'b1;
		ph();
		scl <= 1'b1;
		ph();
		m_oe <= 1'b0;
		ph();
	endtask : sp
	// Eight bits MSB first plus the ack slot; data moves a clock after the fall
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic [8:0] sh;
		for (int i = 8; i >= 0; i--) begin
			@(posedge clk);
			m_oe <= (i == 0) ? 1'b0 : !tx[i-1];
			ph();
			scl <= 1'b1;
			ph();
			sh[i] = sda;
			scl <= 1'b0;
		end
		rx = sh[8:1];
		ack = !sh[0];
	endtask : xb
	// Whole-byte register write; the caller keeps select's upper nibble zero
	task automatic wr(input logic [7:0] a, p, d, output logic ok);
		logic [7:0] rx;
		logic k0, k1, k2;
		st();
		xb(a, rx, k0);
		xb(p, rx, k1);
		xb(d, rx, k2);
		sp();
		ok = k0 & k1 & k2;
	endtask : wr
	// Register read with repeated start; one byte then a NACK
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] rx;
		logic k;
		st();
		xb(8'h30, rx, k);
		xb(p, rx, k);
		st();
		xb(8'h31, rx, k);
		xb(8'hff, d, k);
		sp();
	endtask : rd
endmodule : smbus_ctrl_model

//--- tb/smbus_register_set_select_tb_top.sv
// Self-checking bench: routing, resets and CDR hold reached through the bus
`timescale 1ns/100ps
module smbus_register_set_select_tb_top;
	// Arbitrary identity values
	localparam logic [2:0] REV = 3'h2;
	localparam logic [4:0] DID = 5'h0b;
	localparam logic [7:0] ID_EXP = {REV, DID};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic scl, m_oe, sda_oe, sda, sda_out;
	logic [3:0] addr_strap, cap;
	logic int_a = 1'b0;
	logic int_b = 1'b0;
	logic sig_det_a = 1'b0;
	logic sig_det_b = 1'b0;
	logic cdr_hold_a, cdr_hold_b, lock_start_a, lock_start_b;
	logic [1:0] adapt_mode_a, adapt_mode_b;
	integer seed = 35;
	integer errors = 0;
	integer samples_checked = 0;
	logic [7:0] starts = 8'h00;
	logic [7:0] exp_q[$];
	logic [7:0] got, ev, rnd;
	logic ok;
	event res_ev;
	// Pulled-up wire; the device puts its own drive value on it while enabled
	assign sda = (sda_oe ? sda_out : 1'b1) & !m_oe;
	always #12.5 clk = !clk;
	// Hold-release pulses: channel A in the low nibble, B in the high one
	always @(posedge clk) starts <= starts + {3'h0, lock_start_b, 3'h0, lock_start_a};
	////////////////////////////////////////////////////////////////
	smbus_register_set_select #(.DEV_REV(REV), .DEV_ID(DID)) smbus_register_set_select_i (
		.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe),
		.addr_strap(addr_strap), .int_a(int_a), .int_b(int_b), .sig_det_a(sig_det_a),
		.sig_det_b(sig_det_b), .cdr_hold_a(cdr_hold_a), .cdr_hold_b(cdr_hold_b),
		.lock_start_a(lock_start_a), .lock_start_b(lock_start_b),
		.adapt_mode_a(adapt_mode_a), .adapt_mode_b(adapt_mode_b));
	smbus_ctrl_model smbus_ctrl_model_i (.clk(clk), .sda(sda), .scl(scl), .m_oe(m_oe));
	////////////////////////////////////////////////////////////////
	// Oldest note against each result as it appears
	always @(res_ev) begin
		ev = exp_q.pop_front();
		samples_checked++;
		if (got !== ev) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, ev);
		end
	end
	// Note an expectation and hand the result over; the delay lets the watcher run
	task automatic note(input logic [7:0] e, input logic [7:0] g);
		exp_q.push_back(e);
		got = g;
		-> res_ev;
		#1;
	endtask : note
	task automatic rc(input logic [7:0] p, input logic [7:0] e);
		logic [7:0] d;
		smbus_ctrl_model_i.rd(p, d);
		note(e, d);
	endtask : rc
	task automatic w(input logic [7:0] p, input logic [7:0] d);
		smbus_ctrl_model_i.wr(8'h30, p, d, ok);
		note(8'h01, {7'h0, ok});
	endtask : w
	task automatic test_done;
		$display("checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		addr_strap = 4'($random(seed));
		cap = addr_strap;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		addr_strap <= ~cap; // Pin now differs from the captured level
		repeat (2) @(posedge clk);
		rc(8'h00, 8'h00);
		rc(8'h01, ID_EXP);
		w(8'h06, 8'h0a);
		rc(8'h00, {cap, 4'h0});
		smbus_ctrl_model_i.wr(8'h32, 8'h06, 8'h00, ok);
		note(8'h00, {7'h0, ok});
		rc(8'h06, 8'h0a);
		$display("strap and address done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			int_a <= i[1];
			int_b <= i[0];
			rc(8'h05, {4'h0, i[1:0], 2'h0});
		end
		w(8'h04, 8'h40);
		rc(8'h04, 8'h00);
		rc(8'h06, 8'h00);
		rc(8'h00, 8'h00);
		$display("flags and shared reset done");
		rnd = {4'($random(seed)), 4'h5};
		w(8'h06, rnd);
		w(8'hff, 8'h04);
		w(8'h31, 8'h20);
		w(8'hff, 8'h05);
		w(8'h31, 8'h40);
		note(8'h12, {2'h0, adapt_mode_a, 2'h0, adapt_mode_b});
		rc(8'hff, 8'h00);
		w(8'hff, 8'h0c);
		w(8'h31, 8'h60);
		note(8'h33, {2'h0, adapt_mode_a, 2'h0, adapt_mode_b});
		w(8'hff, 8'h05);
		w(8'h31, 8'h40);
		w(8'hff, 8'h0c);
		rc(8'h31, 8'h60);
		w(8'hff, 8'h0d);
		rc(8'h31, 8'h40);
		w(8'hff, 8'h00);
		rc(8'h06, rnd);
		$display("select routing done");
		w(8'hff, 8'h0c);
		w(8'h0a, 8'h0c);
		@(posedge clk);
		sig_det_a <= 1'b1;
		note(8'h03, {6'h0, cdr_hold_a, cdr_hold_b});
		rc(8'h31, 8'h60);
		rc(8'h0a, 8'h0c);
		w(8'h0a, 8'h08);
		note(8'h00, {6'h0, cdr_hold_a, cdr_hold_b});
		note(8'h01, starts);
		note(8'h03, {6'h0, adapt_mode_a});
		w(8'hff, 8'h04);
		w(8'h00, 8'h04);
		rc(8'h00, 8'h00);
		rc(8'h31, 8'h00);
		rc(8'h0a, 8'h00);
		w(8'hff, 8'h05);
		rc(8'h31, 8'h40);
		rc(8'h0a, 8'h08);
		$display("channel resets done");
		test_done();
	end
endmodule : smbus_register_set_select_tb_top
